// *** can_btl_pkg.sv ***
// constants and types shared by the bit timing and transmit driver block
package can_btl_pkg;
  localparam logic [7:0] ADDR_TIMING0   = 8'h06;
  localparam logic [7:0] ADDR_TIMING1   = 8'h07;
  localparam logic [7:0] ADDR_DRV_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_DIV = 8'h1F;
  localparam logic [7:0] ADDR_STATUS    = 8'h40;

  localparam int BRP_LSB     = 0;
  localparam int BRP_W       = 6;
  localparam int SJW_LSB     = 6;
  localparam int SJW_W       = 2;
  localparam int SAM_BIT     = 7;
  localparam int FIRST_TIME_SEGMENT_LSB   = 0;
  localparam int FIRST_TIME_SEGMENT_W     = 4;
  localparam int SECOND_TIME_SEGMENT_LSB   = 4;
  localparam int SECOND_TIME_SEGMENT_W     = 3;
  localparam int REGMODE_BIT = 7;
  localparam int OUTMODE_LSB = 0;
  localparam int PIN_A_LSB   = 2;
  localparam int PIN_B_LSB   = 5;
  localparam int POL_OFS     = 0;
  localparam int LO_OFS      = 1;
  localparam int HI_OFS      = 2;

  localparam logic [7:0] TIMING0_RESET  = 8'h00;
  localparam logic [7:0] TIMING1_RESET  = 8'h00;
  localparam logic [7:0] DRV_CTRL_RESET = 8'h00;
  localparam logic       REGMODE_RESET  = 1'b0;
  localparam logic [7:0] LEGACY_READ    = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  typedef enum logic [1:0] {
    OUT_BIPHASE = 2'b00,
    OUT_TEST    = 2'b01,
    OUT_NORMAL  = 2'b10,
    OUT_CLOCK   = 2'b11
  } out_mode_t;

  typedef enum logic [1:0] {
    SEG_SYNC   = 2'b00,
    SEG_FIRST  = 2'b01,
    SEG_SECOND = 2'b11
  } seg_state_t;
endpackage

// *** tx_pin_driver.sv ***
// one transmit pin output stage: driver type and polarity
`timescale 1ns/1ns
module tx_pin_driver (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic active,
  input  wire logic data,
  input  wire logic hi_en,
  input  wire logic lo_en,
  input  wire logic pol,
  output logic      pin_out,
  output logic      pin_oe
);
  wire lo_on = lo_en & (data == pol);
  wire hi_on = hi_en & (data != pol);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= hi_on;
      pin_oe  <= active & (lo_on | hi_on);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_float;
    !hi_en && !lo_en |=> !pin_oe;
  endproperty
  a_float: assert property (p_float) else $error("pin driven with no enable");

  property p_pull_down;
    active && !hi_en && lo_en && data == pol |=> pin_oe && !pin_out;
  endproperty
  a_pull_down: assert property (p_pull_down) else $error("low side not on");

  property p_push_pull;
    active && hi_en && lo_en |=> pin_oe && pin_out == $past(data ^ pol);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull level");
endmodule

// *** can_bit_timing_and_tx_driver.sv ***
// bit timing, sampling, configuration registers and transmit output stage
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
module can_bit_timing_and_tx_driver (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       reset_mode,
  input  wire logic       sleep_mode,
  input  wire logic       tx_bit,
  input  wire logic       rx_pin,
  output logic            quantum_tick,
  output logic            bit_start,
  output logic            sample_point,
  output logic            sampled_bit,
  output logic            tx_pin_a_out,
  output logic            tx_pin_a_oe,
  output logic            tx_pin_b_out,
  output logic            tx_pin_b_oe
);
  import can_btl_pkg::*;

  logic [7:0] timing0;
  logic [7:0] timing1;
  logic [7:0] drv_ctrl;
  logic       ext_mode;
  logic [7:0] next_rdata;
  logic [6:0] presc_cnt;
  logic       osc_half;
  logic       rx_s1;
  logic       rx_s2;
  logic       rx_s3;
  logic       rx_level;
  logic       edge_pend;
  logic [1:0] hist;
  seg_state_t state;
  logic [4:0] qcnt;
  logic [4:0] seg1_len;
  logic [4:0] seg2_len;
  logic       resync_done;
  logic       phase;
  logic       test_bit;

  // register port; writes only land in reset mode
  wire reg_wr_ok   = wr & reset_mode;
  wire wr_t0       = reg_wr_ok & (addr == ADDR_TIMING0);
  wire wr_t1       = reg_wr_ok & (addr == ADDR_TIMING1);
  wire wr_drv      = reg_wr_ok & (addr == ADDR_DRV_CTRL);
  wire wr_cd       = reg_wr_ok & (addr == ADDR_CLOCK_DIV);
  wire legacy_hide = ~reset_mode & ~ext_mode;
  wire [7:0] status_word = {4'h0, phase, 2'(state), sampled_bit};

  assign next_rdata =
    (addr == ADDR_TIMING0)   ? (legacy_hide ? LEGACY_READ : timing0) :
    (addr == ADDR_TIMING1)   ? (legacy_hide ? LEGACY_READ : timing1) :
    (addr == ADDR_DRV_CTRL)  ? (legacy_hide ? LEGACY_READ : drv_ctrl) :
    (addr == ADDR_CLOCK_DIV) ? {ext_mode, 7'h00} :
    (addr == ADDR_STATUS)    ? status_word : UNMAPPED_READ;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      timing0  <= TIMING0_RESET;
      timing1  <= TIMING1_RESET;
      drv_ctrl <= DRV_CTRL_RESET;
      ext_mode <= REGMODE_RESET;
      rdata    <= 8'h00;
    end else begin
      if (wr_t0) timing0 <= wdata;
      if (wr_t1) timing1 <= wdata;
      if (wr_drv) drv_ctrl <= wdata;
      if (wr_cd) ext_mode <= wdata[REGMODE_BIT];
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // fields
  wire [BRP_W-1:0] prescale = timing0[BRP_LSB +: BRP_W];
  wire [4:0] sjw_q   = {3'h0, timing0[SJW_LSB +: SJW_W]} + 5'h01;
  wire       triple  = timing1[SAM_BIT];
  wire [4:0] first_time_segment_q = {1'b0, timing1[FIRST_TIME_SEGMENT_LSB +: FIRST_TIME_SEGMENT_W]} + 5'h01;
  wire [4:0] second_time_segment_q = {2'h0, timing1[SECOND_TIME_SEGMENT_LSB +: SECOND_TIME_SEGMENT_W]} + 5'h01;
  out_mode_t mode;
  assign mode = out_mode_t'(drv_ctrl[OUTMODE_LSB +: 2]);

  // quantum: counter wraps after 2*(prescale+1) clocks
  wire q_tick = ~reset_mode & (presc_cnt == {prescale, 1'b1});
  assign quantum_tick = q_tick;

  always_ff @(posedge clk) begin
    if (!rstn || reset_mode || q_tick) begin
      presc_cnt <= 7'h00;
    end else begin
      presc_cnt <= presc_cnt + 7'h01;
    end
  end

  // half-rate system tick for test output mode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc_half <= 1'b0;
    end else begin
      osc_half <= ~osc_half;
    end
  end

  // receive pin: three stages, level accepted when the last two agree
  wire rx_agree = (rx_s2 == rx_s3);
  wire rx_fall  = rx_agree & ~rx_s3 & rx_level;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
      rx_level <= 1'b1;
    end else begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_agree) rx_level <= rx_s3;
    end
  end

  // an edge is held until the next quantum; a new edge beats the clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      edge_pend <= 1'b0;
    end else if (rx_fall) begin
      edge_pend <= 1'b1;
    end else if (q_tick) begin
      edge_pend <= 1'b0;
    end
  end

  // resync at most once per bit; sync segment edges need no correction
  wire       resync_now = edge_pend & ~resync_done;
  wire [4:0] late_err   = qcnt + 5'h01;
  wire [4:0] late_jump  = (late_err < sjw_q) ? late_err : sjw_q;
  wire       resync_1   = resync_now & (state == SEG_FIRST);
  wire       resync_2   = resync_now & (state == SEG_SECOND);
  wire [4:0] seg1_end   = seg1_len + (resync_1 ? late_jump : 5'h00);
  wire [4:0] seg2_left  = seg2_len - qcnt;
  wire       early_jump = resync_2 & (seg2_left <= sjw_q);
  wire       seg2_done  = (qcnt == seg2_len - 5'h01) | early_jump;
  wire       sample_w   = q_tick & (state == SEG_FIRST) &
                          (qcnt == seg1_end - 5'h01);
  wire       bit_start_w = q_tick & (state == SEG_SECOND) & seg2_done;

  always_ff @(posedge clk) begin
    if (!rstn || reset_mode) begin
      state       <= SEG_SYNC;
      qcnt        <= 5'h00;
      seg1_len    <= 5'h01;
      seg2_len    <= 5'h01;
      resync_done <= 1'b0;
    end else if (q_tick) begin
      case (state)
        SEG_SYNC: begin
          state       <= SEG_FIRST;
          qcnt        <= 5'h00;
          seg1_len    <= first_time_segment_q;
          seg2_len    <= second_time_segment_q;
          resync_done <= 1'b0;
        end
        SEG_FIRST: begin
          seg1_len <= seg1_end;
          if (resync_1) resync_done <= 1'b1;
          if (qcnt == seg1_end - 5'h01) begin
            state <= SEG_SECOND;
            qcnt  <= 5'h00;
          end else begin
            qcnt <= qcnt + 5'h01;
          end
        end
        SEG_SECOND: begin
          if (resync_2) resync_done <= 1'b1;
          if (resync_2 && !early_jump) seg2_len <= seg2_len - sjw_q;
          if (seg2_done) begin
            state <= SEG_SYNC;
            qcnt  <= 5'h00;
          end else begin
            qcnt <= qcnt + 5'h01;
          end
        end
        default: begin
          state <= SEG_SYNC;
          qcnt  <= 5'h00;
        end
      endcase
    end
  end

  // one rx sample per quantum; majority over the last three at the point
  wire majority = (hist[1] & hist[0]) | (hist[1] & rx_level) |
                  (hist[0] & rx_level);
  wire sample_v = triple ? majority : rx_level;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hist         <= 2'h3;
      sampled_bit  <= 1'b1;
      sample_point <= 1'b0;
      bit_start    <= 1'b0;
    end else begin
      if (q_tick) hist <= {hist[0], rx_level};
      if (sample_w) sampled_bit <= sample_v;
      sample_point <= sample_w;
      bit_start    <= bit_start_w;
    end
  end

  // bi-phase pin choice flips after every dominant bit
  always_ff @(posedge clk) begin
    if (!rstn || reset_mode) begin
      phase <= 1'b0;
    end else if (bit_start_w && !tx_bit) begin
      phase <= ~phase;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      test_bit <= 1'b1;
    end else if (osc_half) begin
      test_bit <= rx_level;
    end
  end

  // per-pin data and activity ahead of the driver stages
  wire transmit_clock   = (state == SEG_SYNC) & ~reset_mode;
  wire dom     = ~tx_bit;
  wire biphase = (mode == OUT_BIPHASE) & ~sleep_mode;
  wire a_data  = sleep_mode           ? 1'b1 :
                 (mode == OUT_TEST)   ? test_bit : tx_bit;
  wire b_data  = sleep_mode           ? 1'b1 :
                 (mode == OUT_TEST)   ? test_bit :
                 (mode == OUT_CLOCK)  ? transmit_clock : tx_bit;
  wire a_act   = ~reset_mode & (~biphase | (dom & ~phase));
  wire b_act   = ~reset_mode & (~biphase | (dom & phase));

  tx_pin_driver u_pin_a (
    .clk     (clk),
    .rstn    (rstn),
    .active  (a_act),
    .data    (a_data),
    .hi_en   (drv_ctrl[PIN_A_LSB + HI_OFS]),
    .lo_en   (drv_ctrl[PIN_A_LSB + LO_OFS]),
    .pol     (drv_ctrl[PIN_A_LSB + POL_OFS]),
    .pin_out (tx_pin_a_out),
    .pin_oe  (tx_pin_a_oe)
  );

  tx_pin_driver u_pin_b (
    .clk     (clk),
    .rstn    (rstn),
    .active  (b_act),
    .data    (b_data),
    .hi_en   (drv_ctrl[PIN_B_LSB + HI_OFS]),
    .lo_en   (drv_ctrl[PIN_B_LSB + LO_OFS]),
    .pol     (drv_ctrl[PIN_B_LSB + POL_OFS]),
    .pin_out (tx_pin_b_out),
    .pin_oe  (tx_pin_b_oe)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_wr_locked;
    wr && !reset_mode && addr == ADDR_TIMING0 |=> $stable(timing0);
  endproperty
  a_wr_locked: assert property (p_wr_locked) else $error("write in op mode");

  property p_legacy_ff;
    rd && !reset_mode && !ext_mode && addr == ADDR_DRV_CTRL
      |=> rdata == LEGACY_READ;
  endproperty
  a_legacy_ff: assert property (p_legacy_ff) else $error("legacy read not FF");

  property p_quantum_min;
    q_tick && !reset_mode && prescale == 6'h00
      |=> !q_tick ##1 (q_tick || reset_mode);
  endproperty
  a_quantum_min: assert property (p_quantum_min) else $error("quantum period");

  property p_jump_bound;
    seg1_len <= first_time_segment_q + sjw_q;
  endproperty
  a_jump_bound: assert property (p_jump_bound) else $error("jump too far");

  property p_sync_one;
    q_tick && state == SEG_SYNC |=> state == SEG_FIRST && qcnt == 5'h00;
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync segment length");

  property p_single_sample;
    sample_w && !triple |=> sampled_bit == $past(rx_level) && sample_point;
  endproperty
  a_single_sample: assert property (p_single_sample) else $error("sample");

  property p_float_reset;
    reset_mode |=> !tx_pin_a_oe && !tx_pin_b_oe;
  endproperty
  a_float_reset: assert property (p_float_reset) else $error("pins driven");

  property p_sleep_recessive;
    sleep_mode && !reset_mode && drv_ctrl[PIN_A_LSB + HI_OFS] &&
      drv_ctrl[PIN_A_LSB + LO_OFS]
      |=> tx_pin_a_oe && tx_pin_a_out == !$past(drv_ctrl[PIN_A_LSB]);
  endproperty
  a_sleep_recessive: assert property (p_sleep_recessive) else $error("sleep");

  property p_biphase_float;
    !reset_mode && biphase && tx_bit |=> !tx_pin_a_oe && !tx_pin_b_oe;
  endproperty
  a_biphase_float: assert property (p_biphase_float) else $error("bi-phase");
endmodule

// *** can_bus_line.sv ***
// bus line model: pull-up rests recessive, pin a may feed back to rx
`timescale 1ns/1ns
module can_bus_line (
  input  wire logic pin_a_out,
  input  wire logic pin_a_oe,
  input  wire logic loop_en,
  input  wire logic inject_dom,
  output logic      rx_pin
);
  logic bus_low;
  // a floating line is pulled recessive, never left at a stale level
  assign bus_low = (loop_en & pin_a_oe & ~pin_a_out) | inject_dom;
  assign rx_pin  = ~bus_low;
endmodule

// *** can_bit_timing_and_tx_driver_test.sv ***
// self-checking bench for the bit timing and transmit driver block
`timescale 1ns/1ns
module can_bit_timing_and_tx_driver_test;
  import can_btl_pkg::*;
  logic       clk        = 1'b0;
  logic       rstn       = 1'b0;
  logic [7:0] addr       = 8'h00;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic       reset_mode = 1'b1;
  logic       sleep_mode = 1'b0;
  logic       tx_bit     = 1'b1;
  logic       inject_dom = 1'b0;
  logic [7:0] rdata;
  logic       rx_pin, quantum_tick, bit_start, sample_point, sampled_bit;
  logic       tx_pin_a_out, tx_pin_a_oe, tx_pin_b_out, tx_pin_b_oe;
  logic [3:0] pins;
  int         miscompares     = 0;
  int         samples_checked = 0;

  assign pins = {tx_pin_a_oe, tx_pin_a_out, tx_pin_b_oe, tx_pin_b_out};
  always #2 clk = ~clk;

  can_bit_timing_and_tx_driver can_bit_timing_and_tx_driver_i (
    .clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .reset_mode, .sleep_mode,
    .tx_bit, .rx_pin, .quantum_tick, .bit_start, .sample_point, .sampled_bit,
    .tx_pin_a_out, .tx_pin_a_oe, .tx_pin_b_out, .tx_pin_b_oe);
  // feedback stays off: test mode would otherwise latch its own echo
  can_bus_line can_bus_line_i (.pin_a_out(tx_pin_a_out),
    .pin_a_oe(tx_pin_a_oe), .loop_en(1'b0), .inject_dom, .rx_pin);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(16'(rdata), 16'(exp));
  endtask

  task automatic cfg(input logic [7:0] t0, input logic [7:0] t1,
                     input logic [7:0] oc);
    @(posedge clk);
    reset_mode <= 1'b1;
    tx_bit     <= 1'b1;
    wr_reg(ADDR_TIMING0, t0);
    wr_reg(ADDR_TIMING1, t1);
    wr_reg(ADDR_DRV_CTRL, oc);
    @(posedge clk);
    reset_mode <= 1'b0;
  endtask

  function automatic logic pick(input bit tk);
    return tk ? quantum_tick : bit_start;
  endfunction

  // waits for a pulse, then counts clocks to the next one
  task automatic period(input bit tk, output int n);
    n = 0;
    @(negedge clk);
    while (pick(tk) !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pick(tk) !== 1'b1 && n < 4000);
  endtask

  // bit start then drive tx_bit just after it; pins settle one clock later, read after 3
  task automatic send_bit(input logic d);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bit_start !== 1'b1 && n < 4000);
    @(posedge clk);
    tx_bit <= d;
    repeat (3) @(negedge clk);
  endtask

  function automatic logic [1:0] pin_exp(input logic [2:0] c, input logic d);
    logic hi_on;
    hi_on = c[2] & (d != c[0]);
    return {hi_on | (c[1] & (d == c[0])), hi_on};
  endfunction

  task automatic test_regs();
    rd_chk(ADDR_TIMING0, TIMING0_RESET);
    rd_chk(ADDR_CLOCK_DIV, 8'h00);
    wr_reg(ADDR_DRV_CTRL, 8'h1A);
    rd_chk(ADDR_DRV_CTRL, 8'h1A);
    wr_reg(ADDR_TIMING0, 8'hC5);
    wr_reg(ADDR_TIMING1, 8'hA3);
    rd_chk(ADDR_TIMING0, 8'hC5);
    rd_chk(ADDR_TIMING1, 8'hA3);
    rd_chk(8'h30, UNMAPPED_READ);
    @(posedge clk);
    reset_mode <= 1'b0;
    rd_chk(ADDR_TIMING1, LEGACY_READ);
    wr_reg(ADDR_CLOCK_DIV, 8'h80);
    @(posedge clk);
    reset_mode <= 1'b1;
    rd_chk(ADDR_CLOCK_DIV, 8'h00);
    wr_reg(ADDR_CLOCK_DIV, 8'hFF);
    rd_chk(ADDR_CLOCK_DIV, 8'h80);
    @(posedge clk);
    reset_mode <= 1'b0;
    wr_reg(ADDR_TIMING0, 8'h11);
    rd_chk(ADDR_TIMING0, 8'hC5);
    rd_chk(ADDR_DRV_CTRL, 8'h1A);
  endtask

  task automatic test_timing();
    logic [7:0] t0 [2] = '{8'h01, 8'h3F};
    logic [7:0] t1 [2] = '{8'h12, 8'h7F};
    int n, q;
    for (int i = 0; i < 2; i++) begin
      cfg(t0[i], t1[i], 8'h00);
      q = 2 * (t0[i][5:0] + 1);
      period(1'b1, n);
      check(16'(n), 16'(q));
      period(1'b0, n);
      check(16'(n), 16'(q * (3 + t1[i][3:0] + t1[i][6:4])));
    end
  endtask

  task automatic test_drivers();
    logic [2:0] c;
    for (int i = 0; i < 16; i++) begin
      c = i[3:1];
      cfg(8'h00, 8'h00, {~c, c, OUT_NORMAL});
      send_bit(i[0]);
      check(16'(pins), 16'({pin_exp(c, i[0]), pin_exp(~c, i[0])}));
    end
  endtask

  task automatic test_float();
    cfg(8'h00, 8'h00, 8'hDA);
    send_bit(1'b0);
    check(16'(pins), 16'h000A);
    @(posedge clk);
    reset_mode <= 1'b1;
    repeat (2) @(negedge clk);
    check(16'(pins & 4'hA), 16'h0000);
    @(posedge clk);
    reset_mode <= 1'b0;
    sleep_mode <= 1'b1;
    repeat (3) @(negedge clk);
    check(16'(pins), 16'h000F);
    @(posedge clk);
    sleep_mode <= 1'b0;
    rstn       <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(16'(pins & 4'hA), 16'h0000);
    @(posedge clk);
    reset_mode <= 1'b1;
    rd_chk(ADDR_DRV_CTRL, DRV_CTRL_RESET);
  endtask

  task automatic test_biphase();
    logic       d [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [3:0] e [5] = '{4'h8, 4'h2, 4'h0, 4'h8, 4'h2};
    cfg(8'h00, 8'h00, {3'b110, 3'b110, OUT_BIPHASE});
    for (int i = 0; i < 5; i++) begin
      send_bit(d[i]);
      check(16'(pins & 4'hA), 16'(e[i]));
    end
  endtask

  task automatic test_clock();
    int n, hi;
    cfg(8'h01, 8'h12, {3'b110, 3'b110, OUT_CLOCK});
    send_bit(1'b1);
    hi = 0;
    for (int i = 0; i < 24; i++) begin
      @(negedge clk);
      if (tx_pin_b_oe === 1'b1 && tx_pin_b_out === 1'b1) hi++;
    end
    check(16'(hi), 16'h0004);
    check(16'(pins[3:2]), 16'h0003);
    // pin b still low in the cycle bit_start is seen, high one clock later
    n = 0;
    while (bit_start !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(16'(pins[1:0]), 16'h0002);
    @(negedge clk);
    check(16'(pins[1:0]), 16'h0003);
  endtask

  task automatic test_mirror();
    logic [7:0] oc [2] = '{8'hD9, 8'hFD};
    for (int i = 0; i < 4; i++) begin
      cfg(8'h00, 8'h00, oc[i[1]]);
      @(posedge clk);
      inject_dom <= i[0];
      repeat (8) @(negedge clk);
      check(16'(tx_pin_a_out), {15'h0000, ~i[0] ^ i[1]});
    end
    @(posedge clk);
    inject_dom <= 1'b0;
  endtask

  task automatic test_sample();
    int n;
    for (int i = 0; i < 4; i++) begin
      cfg(8'h00, {i[1], 7'h12}, 8'h00);
      @(posedge clk);
      inject_dom <= i[0];
      repeat (4) period(1'b0, n);
      n = 0;
      while (sample_point !== 1'b1 && n < 200) begin
        @(negedge clk);
        n++;
      end
      check(16'(sampled_bit), {15'h0000, ~i[0]});
    end
    @(posedge clk);
    inject_dom <= 1'b0;
  endtask

  task automatic test_resync();
    int n;
    cfg(8'h00, 8'h34, 8'h00);
    period(1'b0, n);
    repeat (5) @(negedge clk);
    @(posedge clk);
    inject_dom <= 1'b1;
    // n counts clocks since the bit start seen by period
    n = 5;
    while (bit_start !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    // late edge in the first segment: bit grows by one jump of one quantum
    check(16'(n), 16'h0016);
    @(posedge clk);
    inject_dom <= 1'b0;
  endtask

  initial begin
    #400000;
    miscompares++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    test_regs();
    test_timing();
    test_drivers();
    test_float();
    test_biphase();
    test_clock();
    test_mirror();
    test_sample();
    test_resync();
    final_report();
  end
endmodule
